/* File: src/tso_consts.vh */
// Constants for the transport stream output block
`ifndef TSO_CONSTS_VH
`define TSO_CONSTS_VH
// ****************************************************
// Register map (byte addresses)
// ****************************************************
`define TSO_OFS_CTRL      12'h000
`define TSO_OFS_GPIO      12'h004
`define TSO_OFS_STATUS    12'h008
`define TSO_OFS_IRQ_STAT  12'h00c
`define TSO_OFS_IRQ_MASK  12'h010
// ****************************************************
// Control register fields
// ****************************************************
`define TSO_CTRL_SERIAL   0
`define TSO_CTRL_PFMT     1
`define TSO_CTRL_CFG_A    2
`define TSO_CTRL_CFG_B    3
`define TSO_CTRL_RST      4'h0
// ****************************************************
// General-purpose pin register fields
// ****************************************************
`define TSO_GP_MODE_LO    0
`define TSO_GP_MODE_HI    1
`define TSO_GP_LEVEL      2
`define TSO_GP_CTRL_PIN   3
`define TSO_GP_RST        4'h0
`define TSO_GP_MODE_LOCK  2'h0
`define TSO_GP_MODE_IRQ   2'h1
`define TSO_GP_MODE_SW    2'h2
// ****************************************************
// Interrupt bits
// ****************************************************
`define TSO_IRQ_PKT       0
`define TSO_IRQ_FAIL      1
`define TSO_IRQ_LOCK      2
`define TSO_IRQ_W         3
// ****************************************************
// Stream constants and timing
// ****************************************************
`define TSO_SYNC_BYTE     8'h47
`define TSO_PKT_LEN       8'd188
`define TSO_CLR_EDGES     3'd4
`define TSO_PAR_DIV       4'd4
`define TSO_SER_DIV       4'd1
`endif

/* File: src/tso_top.v */
// Transport stream output framer with APB control and status
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tso_consts.vh"

// What this block does
// - GP pin: lock, low irq, or level
// - Separate control pin set by software
// - Fail flag high across whole bad packet
// - Bad packet bytes pass unmodified otherwise
// - Both cfg bits low: force error bit
// - Start pulse only during sync byte
// - Byte clock made inside, rate per mode
// - Valid strobe high only with data
// - Output is the decoded eight-bit stream
// - Serial select zero: eight parallel lines
// - Serial select one: bits on line zero
// - Route input copies serial set to test pins
// - Async clear; resume four clocks later
module tso_top (
  input wire core_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Decoded stream from error correction, same clock
  input wire [7:0] in_byte,
  input wire in_valid,
  input wire in_uncorrectable,
  output wire in_ready,
  // Pin inputs from outside
  input wire frontend_lock_flag,
  input wire test_pin_stream_route,
  // Stream outputs
  output reg [7:0] stream_data,
  output reg stream_byte_clock,
  output reg valid_byte_strobe,
  output reg packet_start_pulse,
  output reg packet_fail_flag,
  // Open-drain general pins
  output wire gpio_out,
  output wire gpio_oe,
  output wire ctrl_out,
  output wire ctrl_oe,
  // Test port copies of the serial stream
  output reg test_data,
  output reg test_clock,
  output reg test_start,
  output reg test_valid,
  output reg test_fail,
  output wire test_oe,
  // Interrupt
  output wire irq
);

  // ****************************************************
  // Resume counter after clear
  // ****************************************************
  reg [2:0] clr_cnt; // Counts clock edges after release
  wire run; // High once normal operation resumed
  assign run = (clr_cnt == `TSO_CLR_EDGES);

  // Hold off four edges after release of the clear
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_cnt <= 3'h0;
    end else if (!run) begin
      clr_cnt <= clr_cnt + 3'h1;
    end
  end

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  reg lock_s1; // First stage, only read by second
  reg lock_s2; // Synchronised lock
  reg route_s1; // First stage
  reg route_s2; // Synchronised route select

  // Two flops on each outside level
  // Lock and route are slow levels, so the two-cycle lag is harmless
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      route_s1 <= 1'b0;
      route_s2 <= 1'b0;
    end else begin
      lock_s1 <= frontend_lock_flag;
      lock_s2 <= lock_s1;
      route_s1 <= test_pin_stream_route;
      route_s2 <= route_s1;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  reg [3:0] ctrl_reg; // Mode and error-mark config
  reg [3:0] gp_reg; // Pin modes and levels
  reg [2:0] irq_stat; // Sticky events
  reg [2:0] irq_mask; // Enables
  reg lock_d; // Previous lock for edge event
  wire serial_select; // Serial interface chosen
  wire decoder_flag_cfg_a; // Error mark config A
  wire error_mark_cfg_b; // Error mark config B
  wire [1:0] gp_mode; // General pin function
  wire wr_en; // Write takes effect
  wire [2:0] ev; // Events this cycle
  assign serial_select = ctrl_reg[`TSO_CTRL_SERIAL];
  assign decoder_flag_cfg_a = ctrl_reg[`TSO_CTRL_CFG_A];
  assign error_mark_cfg_b = ctrl_reg[`TSO_CTRL_CFG_B];
  assign gp_mode = gp_reg[`TSO_GP_MODE_HI:`TSO_GP_MODE_LO];
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = 1'b0;

  // Control registers; clear returns defaults
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `TSO_CTRL_RST;
      gp_reg <= `TSO_GP_RST; // lock mode by default
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        `TSO_OFS_CTRL: begin
          ctrl_reg <= pwdata[3:0];
        end
        `TSO_OFS_GPIO: begin
          gp_reg <= pwdata[3:0];
        end
        `TSO_OFS_IRQ_MASK: begin
          irq_mask <= pwdata[2:0];
        end
        default: begin
          ctrl_reg <= ctrl_reg; // Unmapped writes ignored
        end
      endcase
    end
  end

  // Sticky status: set wins over write-one-clear
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= 3'h0;
      lock_d <= 1'b0;
    end else begin
      lock_d <= lock_s2;
      if (wr_en && paddr == `TSO_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  // Level interrupt: high while any enabled event is pending
  assign irq = |(irq_stat & irq_mask);

  // ****************************************************
  // Stream engine
  // ****************************************************
  reg [3:0] div_cnt; // Clock divider
  reg [2:0] bit_idx; // Serial bit position
  reg phase; // Low/high half of output clock
  reg busy; // A byte is being presented
  reg [7:0] cur_byte; // Byte on the output
  reg [7:0] byte_no; // Byte index in packet
  reg cur_fail; // Packet is uncorrectable
  reg cur_start; // Current byte is sync
  wire [3:0] div_top; // Half period in clocks
  wire tick; // One-cycle enable from divider
  wire last_slot; // Final half period of a byte
  wire take; // Accept a new byte
  wire is_sync; // Incoming byte is sync
  wire mark_bit; // Force error indicator
  wire [7:0] in_marked; // Byte after error marking
  // Serial needs faster clock; eight bits per byte
  assign div_top = serial_select ? `TSO_SER_DIV : `TSO_PAR_DIV;
  assign tick = run && (div_cnt == div_top - 4'h1);
  assign last_slot = phase && (!serial_select || bit_idx == 3'h7);
  assign take = tick && (!busy || last_slot);
  assign in_ready = take;
  assign is_sync = (in_byte == `TSO_SYNC_BYTE);
  // Byte after sync gets its top bit forced. The packet's verdict was
  // latched with the sync byte, so the mark always agrees with the fail
  // flag even if the decoder's per-byte flag wobbles.
  assign mark_bit = cur_fail && !decoder_flag_cfg_a &&
    !error_mark_cfg_b && (byte_no == 8'd0) && !is_sync;
  // Otherwise pass as received from the decoder
  assign in_marked = {in_byte[7] | mark_bit, in_byte[6:0]};
  assign ev = {lock_s2 & ~lock_d,
    take & in_valid & in_uncorrectable & is_sync,
    take & in_valid & is_sync};

  // Divider producing the bit/byte enable
  // Limitation: a mode change mid-byte garbles that byte, so software
  // should switch between parallel and serial only while idle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 4'h0;
    end else if (!run || tick) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Byte sequencing and packet tracking
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 1'b0;
      bit_idx <= 3'h0;
      busy <= 1'b0;
      cur_byte <= 8'h00;
      byte_no <= 8'd0;
      cur_fail <= 1'b0;
      cur_start <= 1'b0;
    end else if (tick) begin
      phase <= ~phase;
      if (phase && serial_select) begin
        bit_idx <= bit_idx + 3'h1;
      end
      if (take) begin
        bit_idx <= 3'h0;
        phase <= 1'b0;
        busy <= in_valid;
        if (in_valid) begin
          cur_byte <= in_marked;
          cur_start <= is_sync;
          // Fail flag latched at sync, held for packet
          if (is_sync) begin
            cur_fail <= in_uncorrectable;
            byte_no <= 8'd0;
          end else if (byte_no != `TSO_PKT_LEN - 8'd1) begin
            byte_no <= byte_no + 8'd1;
          end
        end
      end
    end
  end

  // ****************************************************
  // Output registers
  // ****************************************************
  wire out_bit; // Serial bit, MSB first
  assign out_bit = cur_byte[3'h7 - bit_idx];

  // Drive stream pins from flops
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stream_data <= 8'h00;
      stream_byte_clock <= 1'b0;
      valid_byte_strobe <= 1'b0;
      packet_start_pulse <= 1'b0;
      packet_fail_flag <= 1'b0;
    end else begin
      if (serial_select) begin
        stream_data <= {7'h00, out_bit};
      end else begin
        stream_data <= cur_byte;
      end
      // Data changes on falling edge, taken on rising
      stream_byte_clock <= phase & busy;
      valid_byte_strobe <= busy;
      // Flags held over all bit periods of a byte
      packet_start_pulse <= busy & cur_start;
      packet_fail_flag <= busy & cur_fail;
    end
  end

  // Test-port copies when routing enabled and serial selected
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      test_data <= 1'b0;
      test_clock <= 1'b0;
      test_start <= 1'b0;
      test_valid <= 1'b0;
      test_fail <= 1'b0;
    end else if (route_s2 && serial_select) begin
      test_data <= out_bit;
      test_clock <= phase & busy;
      test_start <= busy & cur_start;
      test_valid <= busy;
      test_fail <= busy & cur_fail;
    end else begin
      test_data <= 1'b0;
      test_clock <= 1'b0;
      test_start <= 1'b0;
      test_valid <= 1'b0;
      test_fail <= 1'b0;
    end
  end

  // Limitation: pins stay undriven unless routed
  assign test_oe = route_s2;

  // ****************************************************
  // Open-drain pins: enable pulls low
  // ****************************************************
  reg gp_level; // Wanted level of general pin

  // Select general pin function
  always @* begin
    case (gp_mode)
      `TSO_GP_MODE_LOCK: gp_level = lock_s2;
      `TSO_GP_MODE_IRQ: gp_level = ~irq; // active low
      `TSO_GP_MODE_SW: gp_level = gp_reg[`TSO_GP_LEVEL];
      default: gp_level = 1'b1;
    endcase
  end

  assign gpio_out = 1'b0;
  assign gpio_oe = ~gp_level;
  assign ctrl_out = 1'b0;
  assign ctrl_oe = ~gp_reg[`TSO_GP_CTRL_PIN];

  // ****************************************************
  // APB read mux
  // ****************************************************
  // Combinational, so the zero-wait answer stands in the access phase
  always @* begin
    case (paddr)
      `TSO_OFS_CTRL: prdata = {28'h0, ctrl_reg};
      `TSO_OFS_GPIO: prdata = {28'h0, gp_reg};
      `TSO_OFS_STATUS: prdata = {27'h0, route_s2, lock_s2,
        cur_fail, busy, run};
      `TSO_OFS_IRQ_STAT: prdata = {29'h0, irq_stat};
      `TSO_OFS_IRQ_MASK: prdata = {29'h0, irq_mask};
      default: prdata = 32'h0; // Unmapped reads zero
    endcase
  end

endmodule
`default_nettype wire

/* File: bench/tso_sink.sv */
// Demultiplexer stand-in that collects bytes from the stream pins
`timescale 1ns/1ps
`default_nettype none
module tso_sink (
  input wire logic clk_s,
  input wire logic ser,
  input wire logic [7:0] sdata,
  input wire logic vld,
  input wire logic sop,
  input wire logic fail
);
  logic [9:0] q[$]; // Received {start, fail, byte}
  logic [7:0] sh; // Serial assembly, first bit lands highest
  int n = 0; // Bits gathered; whole packets keep it aligned
  // Data changes mid-period, so the clock rise is a safe sample point
  always @(posedge clk_s) begin
    if (vld && !ser) begin
      q.push_back({sop, fail, sdata});
    end else if (vld) begin
      sh = {sh[6:0], sdata[0]};
      n = (n + 1) % 8;
      if (n == 0) begin
        q.push_back({sop, fail, sh});
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tso_props.sv */
// Port assertions for the stream output block
`timescale 1ns/1ps
`default_nettype none
`include "tso_consts.vh"
module tso_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] stream_data,
  input wire logic valid_byte_strobe,
  input wire logic packet_start_pulse,
  input wire logic packet_fail_flag,
  input wire logic gpio_oe,
  input wire logic ctrl_oe,
  input wire logic stream_byte_clock,
  input wire logic test_data,
  input wire logic test_clock,
  input wire logic test_start,
  input wire logic test_valid,
  input wire logic test_fail
);
  // **********
  // Shadow state
  // **********
  logic [3:0] ctl, gp; // Mirrors of written control values
  logic [1:0] age; // Cycles since a pin write, saturating
  logic [4:0] plen; // Start pulse length so far
  wire wr = psel && penable && pwrite;
  wire vld = valid_byte_strobe;
  wire sop = packet_start_pulse;
  wire ok = age == 2'h3; // Pin outputs have settled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {ctl, gp, age, plen} <= '0;
    end else begin
      plen <= sop ? plen + 5'h1 : 5'h0;
      age <= age + {1'b0, !ok};
      if (wr && paddr == `TSO_OFS_CTRL) ctl <= pwdata[3:0];
      if (wr && paddr == `TSO_OFS_GPIO) begin
        gp <= pwdata[3:0];
        age <= 2'h0;
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sync_end;
    sop ##1 !sop;
  endsequence
  start_len_a: assert property ($fell(sop) |->
    plen == (ctl[0] ? 5'd16 : 5'd8)) else $error("start length");
  start_vld_a: assert property (sop |-> vld)
    else $error("start without valid");
  sync_val_a: assert property (sop && !ctl[0] |->
    stream_data == `TSO_SYNC_BYTE) else $error("sync value");
  fail_hold_a: assert property (vld && $past(vld) &&
    $changed(packet_fail_flag) |-> $rose(sop)) else $error("fail moved");
  err_mark_a: assert property (s_sync_end ##0 (vld &&
    packet_fail_flag && ctl == 4'h0) |-> stream_data[7])
    else $error("error mark");
  level_pin_a: assert property (gp[1:0] == `TSO_GP_MODE_SW && ok |->
    gpio_oe == !gp[2]) else $error("level pin");
  ctrl_pin_a: assert property (ok |-> ctrl_oe == !gp[3])
    else $error("control pin");
  idle_rel_a: assert property ($rose(reset_n) |-> !vld [*4])
    else $error("stream ran early");
  test_copy_a: assert property (test_valid |->
    vld && test_data == stream_data[0] &&
    test_clock == stream_byte_clock && test_start == sop &&
    test_fail == packet_fail_flag) else $error("test port copy");
endmodule
bind tso_top tso_props u_props (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .stream_data(stream_data), .valid_byte_strobe(valid_byte_strobe),
  .packet_start_pulse(packet_start_pulse),
  .packet_fail_flag(packet_fail_flag), .gpio_oe(gpio_oe),
  .ctrl_oe(ctrl_oe), .stream_byte_clock(stream_byte_clock),
  .test_data(test_data), .test_clock(test_clock),
  .test_start(test_start), .test_valid(test_valid),
  .test_fail(test_fail)
);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the stream output block
`timescale 1ns/1ps
`default_nettype none
`include "tso_consts.vh"
module tb;
  logic core_clk, reset_n, psel, penable, pwrite, in_valid, in_unc;
  logic lock, route, ser;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0] in_byte, b;
  wire [31:0] prdata;
  wire [7:0] sdata;
  wire pready, in_ready, clk_s, vld, sop, fail, gpio_oe, ctrl_oe, irq;
  int err_count = 0, cmp_count = 0, cyc = 0, t;
  logic [9:0] ex[188]; // Expected {start, fail, byte}
  logic [3:0] cfgs[5] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h0}; // Mode per packet
  tso_top DUT (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .in_byte(in_byte),
    .in_valid(in_valid), .in_uncorrectable(in_unc), .in_ready(in_ready),
    .frontend_lock_flag(lock), .test_pin_stream_route(route),
    .stream_data(sdata), .stream_byte_clock(clk_s),
    .valid_byte_strobe(vld), .packet_start_pulse(sop),
    .packet_fail_flag(fail), .gpio_out(), .gpio_oe(gpio_oe),
    .ctrl_out(), .ctrl_oe(ctrl_oe), .test_data(), .test_clock(),
    .test_start(), .test_valid(), .test_fail(), .test_oe(), .irq(irq)
  );
  tso_sink sink (
    .clk_s(clk_s), .ser(ser), .sdata(sdata), .vld(vld), .sop(sop),
    .fail(fail)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  // **********
  // Tasks
  // **********
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task summarize();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; read data lands in rd
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the slave; only the bench timeout ends a stuck transfer
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // Offer one byte and hold it until the block takes it
  task send(input logic [7:0] v, input logic u);
    {in_byte, in_unc, in_valid} <= {v, u, 1'b1};
    do @(posedge core_clk); while (in_ready !== 1'b1);
  endtask
  task pause();
    repeat (4) @(posedge core_clk);
  endtask
  // Byte i of a packet as it must leave the block
  function automatic logic [9:0] expect_of(int i, logic [7:0] v, logic u,
    logic [3:0] c);
    if (i == 1 && u && c[3:2] == 2'h0) v[7] = 1'b1; // Error mark
    return {i == 0, u, v};
  endfunction
  // One whole packet in the given mode, compared at the sink
  task run_pkt(input logic [3:0] c, input logic u);
    apb(1'b1, `TSO_OFS_CTRL, {28'h0, c});
    {ser, route} <= {c[0], c[0]};
    sink.q.delete();
    for (int i = 0; i < 188; i++) begin
      b = (i == 0) ? `TSO_SYNC_BYTE : 8'($urandom);
      if (i == 1) b[7] = 1'b0; // Mark bit starts clear
      if (i != 0 && b == `TSO_SYNC_BYTE) b = 8'h46; // Only byte 0 is sync
      ex[i] = expect_of(i, b, u, c);
      send(b, u);
    end
    in_valid <= 1'b0;
    t = 0;
    while (sink.q.size() < 188 && ++t < 9000) @(posedge core_clk);
    chk("byte count", sink.q.size(), 188);
    for (int i = 0; i < 188; i++)
      chk("stream byte", sink.q[i], ex[i]);
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, in_valid, in_unc, route, ser} = '0;
    {paddr, pwdata, in_byte, lock} = {12'h0, 32'h0, 8'h0, 1'b1};
    rd = $urandom(32'h2d92);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, `TSO_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int k = 0; k < 2; k++) begin
      lock <= k[0];
      pause();
      chk("lock pin", gpio_oe, !k[0]);
    end
    // Idle and running: run set, lock high, nothing else
    apb(1'b0, `TSO_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h9);
    for (int k = 0; k < 5; k++)
      run_pkt(cfgs[k], k != 4);
    apb(1'b0, `TSO_OFS_IRQ_STAT, 32'h0);
    chk("events", rd, 32'h7);
    apb(1'b1, `TSO_OFS_GPIO, 32'h1);
    // Mask off, mask on, then clear by writing ones
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, k[1] ? `TSO_OFS_IRQ_STAT : `TSO_OFS_IRQ_MASK, k ? 7 : 0);
      pause();
      chk("irq pin", {gpio_oe, irq}, k == 1 ? 2'b11 : 2'b00);
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `TSO_OFS_GPIO, {28'h0, k[1:0], 2'h2});
      pause();
      chk("sw pins", {ctrl_oe, gpio_oe}, 2'(~k[1:0]));
    end
    reset_n <= 1'b0;
    pause();
    reset_n <= 1'b1;
    apb(1'b0, `TSO_OFS_GPIO, 32'h0);
    chk("pin reset", rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
